/* shp_pkg.sv */
// Shared constants and types for the scanner host port and indexed memory
package shp_pkg;

  // Register map (7-bit configuration addresses)
  localparam logic [6:0] ADR_TARGET   = 7'h03;
  localparam logic [6:0] ADR_ADDR_HI  = 7'h04;
  localparam logic [6:0] ADR_ADDR_LO  = 7'h05;
  localparam logic [6:0] ADR_DATA     = 7'h06;
  localparam logic [6:0] ADR_PORT_CFG = 7'h2A;

  // Field positions
  localparam int TGT_COEF_BIT   = 0;
  localparam int TGT_COLOR_LSB  = 1;
  localparam int ADDR_DIR_BIT   = 5;
  localparam int CFG_NIBBLE_BIT = 0;
  localparam int CFG_DRIVE_LSB  = 1;

  // Values after reset
  localparam logic [7:0] TARGET_RST   = 8'h00;
  localparam logic [7:0] ADDR_HI_RST  = 8'h00;
  localparam logic [7:0] ADDR_LO_RST  = 8'h00;
  localparam logic [7:0] PORT_CFG_RST = 8'h00;
  localparam logic [3:0] NIB_IDLE     = 4'h9;   // error_n=1 select=0 pe=0 ack_n=1

  // Wake-up pattern
  localparam logic [7:0] WAKE_B0 = 8'h99;
  localparam logic [7:0] WAKE_B1 = 8'h66;
  localparam logic [7:0] WAKE_B2 = 8'hCC;
  localparam logic [7:0] WAKE_B3 = 8'h33;

  // Timing, in master clock cycles (10 ns each)
  localparam logic [2:0] WAKE_HOLD_CYC  = 3'h4;
  localparam logic [1:0] INIT_DELAY_CYC = 2'h2;

  // Last address before wrap
  localparam logic [12:0] GAMMA_LAST    = 13'h03FF;
  localparam logic [12:0] COEF_LAST_300 = 13'h0AA9;
  localparam logic [12:0] COEF_LAST_600 = 13'h1554;

  typedef enum logic [1:0] {WK_99 = 2'b00, WK_66 = 2'b01, WK_CC = 2'b11, WK_33 = 2'b10}
    shp_wake_type;
  typedef enum logic [1:0] {CY_IDLE = 2'b00, CY_WR = 2'b01, CY_RD = 2'b11} shp_cyc_type;

  typedef struct packed {
    logic error_n;
    logic select;
    logic pe;
    logic ack_n;
    logic busy;
  } shp_status_type;

  typedef struct packed {
    logic        we;
    logic        coef;
    logic [1:0]  color;
    logic [12:0] addr;
    logic [15:0] wdata;
  } shp_mem_cmd_type;

endpackage : shp_pkg

/* shp_host_port.sv */
// Host port front end with wake-up detector and indexed memory port
// Overview of operation
// - target select bit 0 picks gamma (0) or offset/gain memory (1)
// - target select bits 2:1 give colour: 00 red, 01 green, 10 blue
// - in single-channel A mode colour comes from register 26 bits 4:3
// - 13-bit start address from registers 4 and 5 loads the counter
// - bit 5 of register 4 selects reading; reading triggers prefetch
// - counter steps per gamma byte, per two bytes of coefficient
// - counter wraps to 0 after 1023, 2729 or 5460
// - coefficient address 0 is the first valid image pixel
// - register 6 streams bytes to or from the selected memory
// - 6/10 split: first byte offset 5:0 and gain 9:8, then gain 7:0
// - 8/8 split: first byte offset, second byte gain
// - strap low selects the parallel port interface
// - powers up transparent with idle outputs and pass-through lines low
// - pattern 99 66 CC 33 on the data lines leaves transparent mode
// - each pattern byte must stand at least 4 master clocks
// - on wake-up buffer disable high, line hold low, status deasserted
// - register 42 bit 0 selects nibble reads; writes are always bytes
// - register 42 bits 2:1 select the output drive level
// - access is an address write then any number of data cycles
// - init pulse returns to transparent mode in about 2 to 3 clocks
`timescale 1ns/10ps
`default_nettype none

module shp_fifo #(
  parameter int W     = 33,
  parameter int DEPTH = 4
) (
  input  wire logic         clock,     // Master clock
  input  wire logic         rstn,      // Synchronous reset, active low
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Space available
  input  wire logic [W-1:0] in_data,   // Write word
  output logic              out_valid, // Word available
  input  wire logic         out_ready, // Consumer takes word
  output logic [W-1:0]      out_data   // Head word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [PW-1:0] wr_ff;
  logic [PW-1:0] rd_ff;
  logic [CW-1:0] cnt_ff;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  // Flags from occupancy
  assign in_ready  = (cnt_ff != CW'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  // Storage array, no reset needed
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= bump(wr_ff);
      if (pop) rd_ff <= bump(rd_ff);
      cnt_ff <= CW'(cnt_ff + CW'(push) - CW'(pop));
    end
  end
endmodule : shp_fifo

module shp_host_port #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic             clock,                 // Master clock, 100 MHz
  input  wire logic             rstn,                  // Synchronous reset, active low
  input  wire logic             interface_select_strap,// Low selects parallel port
  input  wire logic [7:0]       pp_data_in,            // Data lines in
  output logic [7:0]            pp_data_out,           // Data lines out
  output logic                  pp_data_oe,            // Data lines driven
  input  wire logic             strobe_n,              // Host STROBE
  input  wire logic             autofeed_n,            // Host AUTOFEED
  input  wire logic             init_n,                // Host INIT
  input  wire logic             select_in_n,           // Host SELECT IN
  output shp_pkg::shp_status_type pp_status,           // Status lines to host
  output logic                  pp_status_oe,          // Status lines driven
  output logic                  passthru_buf_disable,  // Printer buffer disable
  output logic                  printer_line_hold,     // Printer latch control
  output logic [1:0]            drive_level,           // Output drive setting
  output logic                  host_port_active,      // Parallel mode strapped
  input  wire logic             single_channel_a,      // Sensor in 1-channel A mode
  input  wire logic [1:0]       cfg26_color,           // Colour from register 26
  input  wire logic             sensor_600dpi,         // Sensor is 600 dpi
  output shp_pkg::shp_mem_cmd_type mem_cmd,            // Memory command
  output logic                  mem_valid,             // Command valid
  input  wire logic             mem_ready,             // Memory takes command
  input  wire logic [15:0]      mem_rdata,             // Read word
  input  wire logic             mem_rvalid             // Read word valid
);
  import shp_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic            upmode_ff;
  logic            transparent_ff, bufdis_ff, hold_ff;
  logic [7:0]      byte_q_ff;
  logic [2:0]      run_ff;
  shp_wake_type    wake_ff, nxt_wake;
  logic            init_q_ff;
  logic [1:0]      init_cnt_ff;
  shp_cyc_type     cy_ff, nxt_cy;
  logic [6:0]      addr_ff;
  logic [7:0]      target_ff, hi_ff, lo_ff, cfg_ff;
  logic [7:0]      dout_ff, rd_byte;
  logic [3:0]      nib_ff;
  logic [12:0]     cnt_ff, nxt_cnt;
  logic            phase_ff, nxt_phase;
  logic [7:0]      first_ff;
  logic [15:0]     pf_data_ff;
  logic            pf_valid_ff, pf_pend_ff, drop_ff;
  logic            fifo_in_ready;
  shp_mem_cmd_type push_cmd;

  function automatic logic [7:0] wake_byte(input shp_wake_type s);
    case (s)
      WK_99:   wake_byte = WAKE_B0;
      WK_66:   wake_byte = WAKE_B1;
      WK_CC:   wake_byte = WAKE_B2;
      WK_33:   wake_byte = WAKE_B3;
      default: wake_byte = WAKE_B0;
    endcase
  endfunction : wake_byte

  // Strap caught while reset is held
  always_ff @(posedge clock) begin
    if (!rstn) upmode_ff <= interface_select_strap;
  end
  wire pp_en = ~upmode_ff;
  assign host_port_active = pp_en;

  // Wake-up detection: a byte counts once seen on 4 successive samples
  wire [2:0] nxt_run  = (pp_data_in != byte_q_ff) ? 3'h1 :
                        (run_ff == WAKE_HOLD_CYC) ? run_ff : 3'(run_ff + 3'h1);
  wire       held_evt = (nxt_run == WAKE_HOLD_CYC) && (run_ff != WAKE_HOLD_CYC);
  wire       watching = transparent_ff && pp_en && strobe_n;
  wire       hit      = pp_data_in == wake_byte(wake_ff);
  wire       wake_done = watching && held_evt && hit && (wake_ff == WK_33);
  wire       init_rise = init_n & ~init_q_ff;
  wire       init_back = (init_cnt_ff == INIT_DELAY_CYC);

  // Pattern state: advance on match, restart on mismatch
  always_comb begin
    nxt_wake = wake_ff;
    if (!watching) begin
      nxt_wake = WK_99;
    end else if (held_evt) begin
      case (wake_ff)
        WK_99:   nxt_wake = hit ? WK_66 : WK_99;
        WK_66:   nxt_wake = hit ? WK_CC : (pp_data_in == WAKE_B0) ? WK_66 : WK_99;
        WK_CC:   nxt_wake = hit ? WK_33 : (pp_data_in == WAKE_B0) ? WK_66 : WK_99;
        WK_33:   nxt_wake = hit ? WK_99 : (pp_data_in == WAKE_B0) ? WK_66 : WK_99;
        default: nxt_wake = WK_99;
      endcase
    end
  end

  // Detector registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      byte_q_ff <= 8'h00;
      run_ff    <= 3'h0;
      wake_ff   <= WK_99;
    end else begin
      byte_q_ff <= pp_data_in;
      run_ff    <= nxt_run;
      wake_ff   <= nxt_wake;
    end
  end

  // Init rising edge delay
  always_ff @(posedge clock) begin
    if (!rstn) begin
      init_q_ff   <= 1'b1;
      init_cnt_ff <= 2'h0;
    end else begin
      init_q_ff   <= init_n;
      init_cnt_ff <= init_rise ? 2'h1 : init_back ? 2'h0 :
                     (init_cnt_ff != 2'h0) ? 2'(init_cnt_ff + 2'h1) : 2'h0;
    end
  end

  // Transparent state and pass-through controls
  always_ff @(posedge clock) begin
    if (!rstn) begin
      transparent_ff <= 1'b1;
      bufdis_ff      <= 1'b0;
      hold_ff        <= 1'b0;
    end else if (init_back && pp_en) begin
      transparent_ff <= 1'b1;
      bufdis_ff      <= 1'b0;
      hold_ff        <= 1'b1;
    end else if (wake_done) begin
      transparent_ff <= 1'b0;
      bufdis_ff      <= 1'b1;
      hold_ff        <= 1'b0;
    end
  end
  assign passthru_buf_disable = bufdis_ff;
  assign printer_line_hold    = hold_ff;

  // Host cycle decode: address write, data write, data read
  wire active    = ~transparent_ff & pp_en;
  wire idle      = active && (cy_ff == CY_IDLE);
  wire is_port   = (addr_ff == ADR_DATA);
  wire coef      = target_ff[TGT_COEF_BIT];
  wire reading   = hi_ff[ADDR_DIR_BIT];
  wire nibble    = cfg_ff[CFG_NIBBLE_BIT];
  wire wr_addr   = idle && !strobe_n && !select_in_n;
  wire wr_req    = idle && !strobe_n && !autofeed_n && select_in_n;
  wire rd_req    = idle && strobe_n && !autofeed_n;
  wire wr_go     = wr_req && (!is_port || fifo_in_ready);
  wire rd_go     = rd_req && (!is_port || pf_valid_ff);
  wire port_wr   = wr_go && is_port;
  wire port_rd   = rd_go && is_port;
  wire ld_hi     = wr_go && (addr_ff == ADR_ADDR_HI);
  wire ld_lo     = wr_go && (addr_ff == ADR_ADDR_LO);
  wire [1:0] color = single_channel_a ? cfg26_color :
                     target_ff[TGT_COLOR_LSB +: 2];
  wire [12:0] limit = !coef ? GAMMA_LAST :
                      sensor_600dpi ? COEF_LAST_600 : COEF_LAST_300;
  wire [12:0] cnt_inc = (cnt_ff == limit) ? 13'h0000 : 13'(cnt_ff + 13'h0001);
  wire wr_push   = port_wr && (!coef || phase_ff);
  wire pf_push   = reading && !pf_valid_ff && !pf_pend_ff && fifo_in_ready &&
                   (cy_ff == CY_IDLE) && !wr_req && !ld_hi && !ld_lo;
  wire push      = wr_push || pf_push;

  // Command toward memory; coefficient words pack first byte high
  assign push_cmd = '{we: wr_push, coef: coef, color: color, addr: cnt_ff,
                      wdata: coef ? {first_ff, pp_data_in} :
                             {8'h00, pp_data_in}};

  // Read data selection
  wire [7:0] port_byte = (coef && !phase_ff) ? pf_data_ff[15:8] : pf_data_ff[7:0];
  assign rd_byte = (addr_ff == ADR_TARGET)   ? target_ff :
                   (addr_ff == ADR_ADDR_HI)  ? hi_ff :
                   (addr_ff == ADR_ADDR_LO)  ? lo_ff :
                   is_port                   ? port_byte :
                   (addr_ff == ADR_PORT_CFG) ? cfg_ff : 8'h00;

  // Cycle state: busy stands from take until host releases strobes
  always_comb begin
    nxt_cy = cy_ff;
    case (cy_ff)
      CY_IDLE: nxt_cy = (wr_addr || wr_go) ? CY_WR : rd_go ? CY_RD : CY_IDLE;
      CY_WR:   nxt_cy = (select_in_n && autofeed_n) ? CY_IDLE : CY_WR;
      CY_RD:   nxt_cy = autofeed_n ? CY_IDLE : CY_RD;
      default: nxt_cy = CY_IDLE;
    endcase
    if (!active) nxt_cy = CY_IDLE;
  end

  // Configuration registers and read latches
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cy_ff     <= CY_IDLE;
      addr_ff   <= 7'h00;
      target_ff <= TARGET_RST;
      hi_ff     <= ADDR_HI_RST;
      lo_ff     <= ADDR_LO_RST;
      cfg_ff    <= PORT_CFG_RST;
      dout_ff   <= 8'h00;
      nib_ff    <= NIB_IDLE;
    end else begin
      cy_ff <= nxt_cy;
      if (wr_addr) addr_ff <= pp_data_in[6:0];
      if (wr_go && addr_ff == ADR_TARGET) target_ff <= pp_data_in;
      if (ld_hi) hi_ff <= pp_data_in;
      if (ld_lo) lo_ff <= pp_data_in;
      if (wr_go && addr_ff == ADR_PORT_CFG) cfg_ff <= pp_data_in;
      if (rd_go) dout_ff <= rd_byte;
      if (!active || (init_back && pp_en)) nib_ff <= NIB_IDLE;
      else if (rd_go && nibble) nib_ff <= rd_byte[3:0];
      else if (cy_ff == CY_RD && autofeed_n && nibble) nib_ff <= dout_ff[7:4];
    end
  end

  // Pins toward the host
  assign pp_data_out  = dout_ff;
  assign pp_data_oe   = (cy_ff == CY_RD) && !nibble;
  assign pp_status    = '{error_n: nib_ff[3], select: nib_ff[2], pe: nib_ff[1],
                          ack_n: nib_ff[0], busy: cy_ff != CY_IDLE};
  assign pp_status_oe = ~transparent_ff & pp_en;
  assign drive_level  = cfg_ff[CFG_DRIVE_LSB +: 2];

  // Address counter and byte phase
  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_phase = phase_ff;
    if (ld_hi) begin
      nxt_cnt   = {pp_data_in[4:0], lo_ff};
      nxt_phase = 1'b0;
    end else if (ld_lo) begin
      nxt_cnt   = {hi_ff[4:0], pp_data_in};
      nxt_phase = 1'b0;
    end else if (port_wr || port_rd) begin
      if (!coef || phase_ff) nxt_cnt = cnt_inc;
      nxt_phase = coef & ~phase_ff;
    end
  end

  // Counter, first byte hold and prefetch buffer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_ff      <= 13'h0000;
      phase_ff    <= 1'b0;
      first_ff    <= 8'h00;
      pf_data_ff  <= 16'h0000;
      pf_valid_ff <= 1'b0;
      pf_pend_ff  <= 1'b0;
      drop_ff     <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      phase_ff <= nxt_phase;
      if (port_wr && coef && !phase_ff) first_ff <= pp_data_in;
      if (ld_hi || ld_lo) begin
        pf_valid_ff <= 1'b0;
        drop_ff     <= pf_pend_ff;
        pf_pend_ff  <= 1'b0;
      end else if (mem_rvalid && drop_ff) begin
        drop_ff <= 1'b0;
      end else if (mem_rvalid && pf_pend_ff) begin
        pf_data_ff  <= mem_rdata;
        pf_valid_ff <= 1'b1;
        pf_pend_ff  <= 1'b0;
      end else begin
        if (pf_push) pf_pend_ff <= 1'b1;
        if (port_rd && (!coef || phase_ff)) pf_valid_ff <= 1'b0;
      end
    end
  end

  // Command buffer toward memory
  shp_fifo #(.W($bits(shp_mem_cmd_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_cmd),
    .out_valid (mem_valid),
    .out_ready (mem_ready),
    .out_data  (mem_cmd)
  );

  sequence s_last_byte;
    transparent_ff && wake_done;
  endsequence
  sequence s_released;
    !transparent_ff && bufdis_ff && !hold_ff;
  endsequence

  wake_exit_a: assert property (s_last_byte |=> s_released ##0 pp_status_oe &&
      pp_status.error_n && pp_status.ack_n && !pp_status.pe && !pp_status.select)
    else $error("wake-up exit left wrong pin states");
  wake_miss_a: assert property (watching && held_evt && !hit &&
      pp_data_in != WAKE_B0 |=> wake_ff == WK_99)
    else $error("mismatching byte did not restart search");
  init_return_a: assert property (pp_en && $rose(init_n) ##1 init_n [*2]
      |=> transparent_ff && hold_ff && !bufdis_ff && !pp_status_oe)
    else $error("init pulse did not restore transparent mode");
  wrap_point_a: assert property ((port_wr || port_rd) && !ld_hi && !ld_lo &&
      (!coef || phase_ff) && cnt_ff == limit |=> cnt_ff == 13'h0000)
    else $error("address counter missed its wrap");
  coef_pair_a: assert property (port_wr && coef && !phase_ff |=> $stable(cnt_ff) && phase_ff)
    else $error("coefficient address stepped on first byte");
  gamma_step_a: assert property (port_wr && (!coef || phase_ff) |=> cnt_ff ==
      (($past(cnt_ff) == $past(limit)) ? 13'h0000 : 13'($past(cnt_ff) + 13'h0001)))
    else $error("address did not step after a full word");
  color_sel_a: assert property (push && single_channel_a |-> push_cmd.color == cfg26_color)
    else $error("single-channel colour not taken from register 26");
  target_sel_a: assert property (push && !single_channel_a |->
      push_cmd.coef == target_ff[0] && push_cmd.color == target_ff[2:1])
    else $error("target or colour field misrouted");
  port_data_a: assert property (port_rd && !coef |=> pp_data_out == $past(pf_data_ff[7:0]))
    else $error("gamma read returned wrong byte");
  nibble_hiz_a: assert property (cy_ff == CY_RD && nibble |-> !pp_data_oe)
    else $error("data lines driven in nibble mode");
endmodule : shp_host_port

`default_nettype wire

/* shp_host_model.sv */
// Host-side parallel port partner model with bus cycle and wake-up tasks
`timescale 1ns/10ps
`default_nettype none

module shp_host_model
  import shp_pkg::*;
(
  input  wire logic                    clock,       // Master clock
  input  wire logic [7:0]              dev_data,    // Device data out
  input  wire logic                    dev_oe,      // Device drives data
  input  wire shp_pkg::shp_status_type status,      // Status lines
  output logic [7:0]                   line_data,   // Resolved data lines
  output logic                         strobe_n,    // Host STROBE
  output logic                         autofeed_n,  // Host AUTOFEED
  output logic                         init_n,      // Host INIT
  output logic                         select_in_n, // Host SELECT IN
  output logic                         tmo          // A wait ran out
);
  logic [7:0] hd;   // Byte the host puts on the lines
  logic       hdrv; // Host drives the data lines

  // Released lines show the inverse of the last value, never a stale copy
  assign line_data = dev_oe ? dev_data : (hdrv ? hd : ~hd);

  // Idle levels at time zero
  initial begin
    hd          = 8'h00;
    hdrv        = 1'b1;
    strobe_n    = 1'b1;
    autofeed_n  = 1'b1;
    init_n      = 1'b1;
    select_in_n = 1'b1;
    tmo         = 1'b0;
  end

  // Bounded wait for busy to reach a level
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (status.busy !== lvl && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (n == 200) tmo <= 1'b1;
  endtask : wait_busy

  // One bus cycle: 0 address write, 1 data write, 2 data read
  task automatic cyc(input logic [1:0] k, input logic [7:0] b, input logic nib,
                     output logic [7:0] r);
    @(posedge clock);
    hd          <= b;
    hdrv        <= (k != 2'h2);
    strobe_n    <= (k == 2'h2);
    select_in_n <= (k != 2'h0);
    autofeed_n  <= (k == 2'h0);
    wait_busy(1'b1);
    r = nib ? {4'h0, status[4:1]} : dev_data;
    strobe_n    <= 1'b1;
    select_in_n <= 1'b1;
    autofeed_n  <= 1'b1;
    wait_busy(1'b0);
    if (nib) r[7:4] = status[4:1];
    hdrv <= 1'b1;
  endtask : cyc

  // One wake-up byte held for five edges, controls untouched
  task automatic wake(input logic [7:0] b);
    @(posedge clock);
    hd <= b;
    repeat (4) @(posedge clock);
  endtask : wake

  // Low pulse on the initialise line
  task automatic pulse_init();
    @(posedge clock);
    init_n <= 1'b0;
    repeat (2) @(posedge clock);
    init_n <= 1'b1;
  endtask : pulse_init
endmodule : shp_host_model

`default_nettype wire

/* shp_host_port_bench.sv */
// Self-checking bench for the scanner host port
`timescale 1ns/10ps
`default_nettype none

module shp_host_port_bench;
  import shp_pkg::*;
  logic            clock;
  logic            rstn;
  logic            sca;
  logic [1:0]      c26;
  logic            dpi6;
  logic            mem_ready;
  logic [15:0]     mem_rdata;
  logic            mem_rvalid;
  logic            strap;
  int              seed;
  int              failures;
  int              cmp_count;
  shp_mem_cmd_type q[$];
  shp_mem_cmd_type cmd_rec;
  wire logic [7:0] line_data;
  wire logic [7:0] pp_data_out;
  wire logic       pp_data_oe;
  wire logic       strobe_n;
  wire logic       autofeed_n;
  wire logic       init_n;
  wire logic       select_in_n;
  wire logic       host_tmo;
  wire logic       pp_status_oe;
  wire logic       buf_dis;
  wire logic       line_hold;
  wire logic [1:0] drive_level;
  wire logic       mem_valid;
  wire logic       hpa;
  wire shp_status_type  pp_status;
  wire shp_mem_cmd_type mem_cmd;
  wire logic [7:0] stat = {pp_status_oe, buf_dis, line_hold, pp_status};

  shp_host_port shp_host_port_inst (.clock(clock), .rstn(rstn), .interface_select_strap(strap),
    .pp_data_in(line_data), .pp_data_out(pp_data_out), .pp_data_oe(pp_data_oe),
    .strobe_n(strobe_n), .autofeed_n(autofeed_n), .init_n(init_n), .select_in_n(select_in_n),
    .pp_status(pp_status), .pp_status_oe(pp_status_oe), .passthru_buf_disable(buf_dis),
    .printer_line_hold(line_hold), .drive_level(drive_level), .host_port_active(hpa),
    .single_channel_a(sca), .cfg26_color(c26), .sensor_600dpi(dpi6), .mem_cmd(mem_cmd),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid));

  shp_host_model shp_host_model_inst (.clock(clock), .dev_data(pp_data_out),
    .dev_oe(pp_data_oe), .status(pp_status), .line_data(line_data), .strobe_n(strobe_n),
    .autofeed_n(autofeed_n), .init_n(init_n), .select_in_n(select_in_n), .tmo(host_tmo));

  // Clock and memory side that stalls at random and answers reads next cycle
  always #5 clock = ~clock;
  always @(posedge clock) begin
    mem_ready  <= 1'($random(seed));
    mem_rvalid <= 1'b0;
    if (mem_valid === 1'b1 && mem_ready) begin
      cmd_rec = mem_cmd;
      if (!cmd_rec.we) begin
        cmd_rec.wdata = 16'h0000;
        mem_rvalid    <= 1'b1;
        mem_rdata     <= {2{gv(mem_cmd.addr)}};
      end
      q.push_back(cmd_rec);
    end
  end
  always @(posedge host_tmo) begin
    failures++;
    end_sim();
  end

  function automatic logic [7:0] gv(input logic [12:0] a);
    gv = a[7:0] ^ 8'h5A;
  endfunction : gv

  function automatic shp_mem_cmd_type mk(input logic w, input logic c, input logic [1:0] col,
                                         input logic [12:0] a, input logic [15:0] d);
    mk = '{we: w, coef: c, color: col, addr: a, wdata: d};
  endfunction : mk

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_cmd(input shp_mem_cmd_type got, input shp_mem_cmd_type exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_cmd

  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    shp_host_model_inst.cyc(2'h0, {1'b0, a}, 1'b0, r);
    shp_host_model_inst.cyc(2'h1, d, 1'b0, r);
  endtask : wreg

  task automatic rreg(input logic [6:0] a, input logic nib, output logic [7:0] r);
    shp_host_model_inst.cyc(2'h0, {1'b0, a}, 1'b0, r);
    shp_host_model_inst.cyc(2'h2, 8'h00, nib, r);
  endtask : rreg

  // Bounded wait for n captured memory commands
  task automatic wq(input int n);
    int k;
    k = 0;
    while (q.size() < n && k < 100) begin
      @(posedge clock);
      k++;
    end
    if (k == 100) begin
      failures++;
      end_sim();
    end
  endtask : wq

  // Full wake-up pattern, each byte held for five edges
  task automatic wake_all();
    shp_host_model_inst.wake(WAKE_B0);
    shp_host_model_inst.wake(WAKE_B1);
    shp_host_model_inst.wake(WAKE_B2);
    shp_host_model_inst.wake(WAKE_B3);
  endtask : wake_all

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    logic [7:0]  r;
    logic [7:0]  d [4];
    logic [12:0] la;
    seed = 4;
    clock = 1'b0;
    rstn = 1'b0;
    sca = 1'b0;
    strap = 1'b0;
    c26 = 2'b01;
    dpi6 = 1'b0;
    mem_ready = 1'b0;
    mem_rdata = 16'h0000;
    mem_rvalid = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    chk8(stat, 8'h12);
    chk8({7'h00, hpa}, 8'h01);
    shp_host_model_inst.wake(WAKE_B0);
    shp_host_model_inst.wake(8'h55);
    shp_host_model_inst.wake(WAKE_B1);
    shp_host_model_inst.wake(WAKE_B2);
    shp_host_model_inst.wake(WAKE_B3);
    chk8(stat, 8'h12);
    wake_all();
    repeat (3) @(posedge clock);
    chk8(stat, 8'hD2);
    wreg(ADR_PORT_CFG, 8'h06);
    chk8({6'h00, drive_level}, 8'h03);
    rreg(ADR_PORT_CFG, 1'b0, r);
    chk8(r, 8'h06);
    rreg(7'h10, 1'b0, r);
    chk8(r, 8'h00);
    for (int c = 0; c < 3; c++) begin
      wreg(ADR_TARGET, {5'h00, 2'(c), 1'b0});
      wreg(ADR_ADDR_HI, 8'h03);
      wreg(ADR_ADDR_LO, 8'hFF);
      d[0] = 8'($random(seed));
      d[1] = 8'($random(seed));
      q.delete();
      wreg(ADR_DATA, d[0]);
      wreg(ADR_DATA, d[1]);
      wq(2);
      chk_cmd(q[0], mk(1'b1, 1'b0, 2'(c), 13'h03FF, {8'h00, d[0]}));
      chk_cmd(q[1], mk(1'b1, 1'b0, 2'(c), 13'h0000, {8'h00, d[1]}));
    end
    sca <= 1'b1;
    c26 <= 2'b10;
    for (int s = 0; s < 2; s++) begin
      dpi6 <= 1'(s);
      la = s ? 13'h1554 : 13'h0AA9;
      wreg(ADR_TARGET, 8'h01);
      wreg(ADR_ADDR_HI, {3'h0, la[12:8]});
      wreg(ADR_ADDR_LO, la[7:0]);
      foreach (d[i]) d[i] = 8'($random(seed));
      q.delete();
      foreach (d[i]) wreg(ADR_DATA, d[i]);
      wq(2);
      chk_cmd(q[0], mk(1'b1, 1'b1, 2'b10, la, {d[0], d[1]}));
      chk_cmd(q[1], mk(1'b1, 1'b1, 2'b10, 13'h0000, {d[2], d[3]}));
    end
    sca <= 1'b0;
    wreg(ADR_TARGET, 8'h02);
    wreg(ADR_ADDR_LO, 8'h10);
    q.delete();
    wreg(ADR_ADDR_HI, 8'h20);
    rreg(ADR_DATA, 1'b0, r);
    chk8(r, gv(13'h0010));
    rreg(ADR_DATA, 1'b0, r);
    chk8(r, gv(13'h0011));
    chk_cmd(q[0], mk(1'b0, 1'b0, 2'b01, 13'h0010, 16'h0000));
    wreg(ADR_PORT_CFG, 8'h07);
    rreg(ADR_PORT_CFG, 1'b1, r);
    chk8(r, 8'h07);
    shp_host_model_inst.pulse_init();
    repeat (4) @(posedge clock);
    chk8(stat, 8'h32);
    // Second reset with the strap high: the port must stay inert
    rstn  <= 1'b0;
    strap <= 1'b1;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk8({7'h00, hpa}, 8'h00);
    wake_all();
    repeat (3) @(posedge clock);
    chk8(stat, 8'h12);
    end_sim();
  end
endmodule : shp_host_port_bench

`default_nettype wire
